// *** fmsp_baud.v ***
// Bit-rate generator: one-cycle tick at sixteen times the asynchronous bit rate.
// Assumes the fixed-rate select and all settings come from the same clock domain.
`include "fmsp_defines.vh"
module fmsp_baud (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_fixed,
  input wire i_rate_doubling_bit,
  input wire i_t2sel,
  input wire [3:0] i_t1_mode,
  input wire [7:0] i_t1_reload,
  input wire [15:0] i_t2_reload,
  output reg o_tick
);
  reg [1:0] m2_cnt_reg;
  reg [3:0] t1_pre_reg;
  reg [7:0] t1_cnt_reg;
  reg t1_half_reg;
  reg t2_pre_reg;
  reg [15:0] t2_cnt_reg;
  wire m2_last = (m2_cnt_reg == (i_rate_doubling_bit ? `FMSP_M2_LAST_FAST : `FMSP_M2_LAST_SLOW));
  wire t1_step = (t1_pre_reg == `FMSP_T1_PRE_LAST) && (i_t1_mode == `FMSP_T1_AUTO);
  wire t1_ovf = t1_step && (t1_cnt_reg == `FMSP_T1_TOP);
  wire t2_ovf = t2_pre_reg && (t2_cnt_reg == `FMSP_T2_TOP);

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m2_cnt_reg <= 2'h0;
      t1_pre_reg <= 4'h0;
      t1_cnt_reg <= `FMSP_RST_BYTE;
      t1_half_reg <= 1'b0;
      t2_pre_reg <= 1'b0;
      t2_cnt_reg <= `FMSP_RST_CAP;
      o_tick <= 1'b0;
    end else begin
      m2_cnt_reg <= m2_last ? 2'h0 : m2_cnt_reg + 2'h1;
      t1_pre_reg <= (t1_pre_reg == `FMSP_T1_PRE_LAST) ? 4'h0 : t1_pre_reg + 4'h1;
      // Timer 1 waits at its reload value unless it is the bit-rate source; Timer 2 waits whenever it is not selected.
      // Without this the first period after selection could run the whole counter range.
      if (i_fixed || i_t2sel) begin
        t1_cnt_reg <= i_t1_reload;
      end else if (t1_ovf) begin
        t1_cnt_reg <= i_t1_reload;
        t1_half_reg <= ~t1_half_reg;
      end else if (t1_step) begin
        t1_cnt_reg <= t1_cnt_reg + 8'h01;
      end
      t2_pre_reg <= ~t2_pre_reg;
      if (!i_t2sel) begin
        t2_cnt_reg <= i_t2_reload;
      end else if (t2_ovf) begin
        t2_cnt_reg <= i_t2_reload;
      end else if (t2_pre_reg) begin
        t2_cnt_reg <= t2_cnt_reg + 16'h0001;
      end
      if (i_fixed) begin
        o_tick <= m2_last;
      end else if (i_t2sel) begin
        o_tick <= t2_ovf;
      end else begin
        o_tick <= t1_ovf && (i_rate_doubling_bit || t1_half_reg);
      end
    end
  end
endmodule // fmsp_baud

// *** fmsp_defines.vh ***
// Register offsets, field positions, reset values and divider counts of the serial port.
// Assumes inclusion by bare name from the serial port design files.
`ifndef FMSP_DEFINES_VH
`define FMSP_DEFINES_VH
`define FMSP_ADDR_CTRL 8'h98
`define FMSP_ADDR_BUF 8'h99
`define FMSP_ADDR_PWR 8'h87
`define FMSP_ADDR_TIMER_MODE_REGISTER 8'h89
`define FMSP_ADDR_T1RL 8'h8D
`define FMSP_ADDR_TIMER2_CONTROL 8'hC8
`define FMSP_ADDR_CAPL 8'hCA
`define FMSP_ADDR_CAPH 8'hCB
`define FMSP_BIT_MODE_HI 7
`define FMSP_BIT_MODE_LO 6
`define FMSP_BIT_MP 5
`define FMSP_BIT_REN 4
`define FMSP_BIT_TB8 3
`define FMSP_BIT_RB8 2
`define FMSP_BIT_TI 1
`define FMSP_BIT_RI 0
`define FMSP_BIT_RATE_DOUBLING_BIT 7
`define FMSP_BIT_TIMER2_RATE_CLOCK_SELECT 5
`define FMSP_RST_BYTE 8'h00
`define FMSP_RST_CAP 16'h0000
`define FMSP_MODE0 2'h0
`define FMSP_MODE1 2'h1
`define FMSP_MODE2 2'h2
`define FMSP_MODE3 2'h3
`define FMSP_M0_LAST 4'hB
`define FMSP_M0_RISE 4'h6
`define FMSP_M0_LAST_BIT 3'h7
`define FMSP_T1_PRE_LAST 4'hB
`define FMSP_T1_AUTO 4'h2
`define FMSP_T1_TOP 8'hFF
`define FMSP_T2_TOP 16'hFFFF
`define FMSP_M2_LAST_SLOW 2'h3
`define FMSP_M2_LAST_FAST 2'h1
`define FMSP_SUB_LAST 4'hF
`define FMSP_SUB_MID 4'h7
`define FMSP_NBITS_8 4'hA
`define FMSP_NBITS_9 4'hB
`endif

// *** fmsp_peer.sv ***
// Remote serial device: sends asynchronous frames, shifts Mode 0 data both ways.
// Assumes the bench resolves the data pin from the port's enable.
module fmsp_peer (
  input wire i_mclk,
  input wire i_txd,
  input wire i_pin,
  input wire i_oe_n,
  output reg o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] m0_in;
  initial o_rxd = 1'b1;
  // Takes each shifted-out bit on the rising shift clock.
  always @(posedge i_txd) if (!i_oe_n) m0_in <= {i_pin, m0_in[7:1]};
  task automatic send(input [10:0] f, input int n, input int bc);
    for (int k = 0; k < n; k++) begin
      o_rxd <= f[k];
      repeat (bc) @(posedge i_mclk);
    end
    o_rxd <= 1'b1;
  endtask
  // Presents a bit at each falling shift clock, then lets the pull-up return.
  task automatic m0_send(input [7:0] d);
    for (int k = 0; k < 8; k++) begin
      @(negedge i_txd);
      o_rxd <= d[k];
    end
    @(posedge i_txd);
    repeat (7) @(posedge i_mclk);
    o_rxd <= 1'b1;
  endtask
endmodule // fmsp_peer

// *** fmsp_sync.v ***
// Two-flop synchroniser for the receive-data pin.
// Assumes an idle-high line, so both flops reset to one.
module fmsp_sync (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_async,
  output reg o_sync
);
  reg meta_reg;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // fmsp_sync

// *** fmsp_top.v ***
// Four-mode serial port: register file, shift-register mode engine and asynchronous engines.
// Assumes a single-cycle register port on i_mclk and an asynchronous receive-data pin.
//
// Strobed register access is this design's own decision.
`include "fmsp_defines.vh"
// Contract
// - Transmit and receive run together; one received byte buffered, overrun loses the new byte.
// - Buffer write loads transmitter; buffer read returns separate receive register.
// - Mode 0 shifts eight bits LSB first on data pin, clock out at osc/12.
// - Mode 1 character: start 0, eight data bits LSB first, stop 1.
// - Modes 2/3: start, eight data, ninth bit, stop; ninth received, stop ignored.
// - Mode 2 rate is osc/64, or osc/32 with rate doubling set.
// - Any buffer write starts a transmission in every mode.
// - Mode 0 receives when flag clear and enabled; others on start bit if enabled.
// - Modes 2/3 with filter set: receive flag only when ninth bit is 1.
// - Mode 1 with filter set: receive flag only on a valid stop bit.
// - Control bits 7:6 select modes 0 to 3.
// - Transmit flag set after eighth bit (mode 0) or at stop start; software clears.
// - Receive flag set after eighth bit (mode 0) or mid stop; software clears.
// - Mode 1 without filter stores stop bit as received ninth bit.
// - Timer 1 rate is two to doubling bit over 32 times its overflow rate.
// - Timer 1 auto-reload mode overflows every 12 times (256 minus reload) clocks.
// - Clock-select bit picks Timer 2; each roll-over reloads from capture pair.
// - Timer 2 counts at osc/2, giving osc over 32 times (65536 minus reload).
module fmsp_top (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_rxd,
  output reg o_rxd,
  output reg o_rxd_oe_n,
  output reg o_txd
);
  // Character length in bit times, start and stop bits included.
  function [3:0] fmsp_nbits;
    input [1:0] mode;
    begin
      fmsp_nbits = (mode == `FMSP_MODE1) ? `FMSP_NBITS_8 : `FMSP_NBITS_9;
    end
  endfunction

  reg [1:0] mode_reg;
  reg mp_reg;
  reg ren_reg;
  reg tb8_reg;
  reg rb8_reg;
  reg ti_reg;
  reg ri_reg;
  reg [7:0] rx_buf_reg;
  reg rate_doubling_bit_reg;
  reg [7:0] timer_mode_register_reg;
  reg [7:0] t1_reload_reg;
  reg t2sel_reg;
  reg [15:0] cap_reg;

  reg tx_busy_reg;
  reg [10:0] tx_shift_reg;
  reg [3:0] tx_bit_reg;
  reg [3:0] tx_sub_reg;

  reg rx_busy_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_shift_reg;
  reg rx_prev_reg;

  reg m0_busy_reg;
  reg m0_rx_reg;
  reg [3:0] m0_phase_reg;
  reg [2:0] m0_bit_reg;
  reg [7:0] m0_shift_reg;

  reg [7:0] rd_next;
  wire rxd_s;
  wire tick;

  wire wr_ctrl = i_wr && (i_addr == `FMSP_ADDR_CTRL);
  wire wr_buf = i_wr && (i_addr == `FMSP_ADDR_BUF);
  wire async = (mode_reg != `FMSP_MODE0);
  wire mode1 = (mode_reg == `FMSP_MODE1);
  wire [3:0] nbits = fmsp_nbits(mode_reg);

  fmsp_sync u_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async(i_rxd),
    .o_sync(rxd_s)
  );

  fmsp_baud u_baud (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_fixed(mode_reg == `FMSP_MODE2),
    .i_rate_doubling_bit(rate_doubling_bit_reg),
    .i_t2sel(t2sel_reg),
    .i_t1_mode(timer_mode_register_reg[7:4]),
    .i_t1_reload(t1_reload_reg),
    .i_t2_reload(cap_reg),
    .o_tick(tick)
  );

  // Asynchronous transmitter.
  // A buffer write while a character is going out restarts it from its start bit.
  wire tx_bit_end = tx_busy_reg && tick && (tx_sub_reg == `FMSP_SUB_LAST);
  wire ti_set_async = tx_bit_end && (tx_bit_reg == nbits - 4'h2);
  wire tx_ninth = mode1 ? 1'b1 : tb8_reg;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 11'h7FF;
      tx_bit_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else if (wr_buf && async) begin
      tx_busy_reg <= 1'b1;
      tx_shift_reg <= {1'b1, tx_ninth, i_wdata, 1'b0};
      tx_bit_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else if (tx_busy_reg && tick) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_bit_end) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == nbits - 4'h1) begin
          tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Asynchronous receiver, sampling each bit at its middle tick.
  wire rx_mid = rx_busy_reg && tick && (rx_sub_reg == `FMSP_SUB_MID);
  wire rx_done = rx_mid && (rx_bit_reg == nbits - 4'h1);
  wire rx_flag_bit = mode1 ? rxd_s : rx_shift_reg[8];
  wire [7:0] rx_data = mode1 ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
  wire rx_accept = !ri_reg && (!mp_reg || rx_flag_bit);
  wire rx_load_async = rx_done && rx_accept;
  // A falling edge on the synchronised pin while idle is taken as a start bit.
  wire rx_start = !rx_busy_reg && async && ren_reg && rx_prev_reg && !rxd_s;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_busy_reg <= 1'b0;
      rx_sub_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rxd_s;
      if (rx_start) begin
        rx_busy_reg <= 1'b1;
        rx_sub_reg <= 4'h0;
        rx_bit_reg <= 4'h0;
      end else if (!async) begin
        rx_busy_reg <= 1'b0;
      end else if (rx_busy_reg && tick) begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_sub_reg == `FMSP_SUB_LAST) begin
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        if (rx_mid) begin
          if ((rx_bit_reg == 4'h0) && rxd_s) begin
            // A start bit that is high at its middle was a glitch.
            rx_busy_reg <= 1'b0;
          end else if (rx_done) begin
            rx_busy_reg <= 1'b0;
          end else if (rx_bit_reg != 4'h0) begin
            rx_shift_reg <= {rxd_s, rx_shift_reg[8:1]};
          end
        end
      end
    end
  end

  // Shift-register mode: twelve clocks per bit, clock high in the second half.
  wire m0_bit_end = m0_busy_reg && (m0_phase_reg == `FMSP_M0_LAST);
  wire m0_end = m0_bit_end && (m0_bit_reg == `FMSP_M0_LAST_BIT);
  wire ti_set_m0 = m0_end && !m0_rx_reg;
  wire rx_load_m0 = m0_end && m0_rx_reg && !ri_reg;
  // Mode 0 reception restarts by itself as soon as software clears the receive flag.
  wire m0_rx_start = !async && !m0_busy_reg && ren_reg && !ri_reg && !wr_buf;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m0_busy_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_phase_reg <= 4'h0;
      m0_bit_reg <= 3'h0;
      m0_shift_reg <= 8'hFF;
    end else if (wr_buf && !async) begin
      m0_busy_reg <= 1'b1;
      m0_rx_reg <= 1'b0;
      m0_phase_reg <= 4'h0;
      m0_bit_reg <= 3'h0;
      m0_shift_reg <= i_wdata;
    end else if (m0_rx_start) begin
      m0_busy_reg <= 1'b1;
      m0_rx_reg <= 1'b1;
      m0_phase_reg <= 4'h0;
      m0_bit_reg <= 3'h0;
    end else if (async) begin
      m0_busy_reg <= 1'b0;
    end else if (m0_busy_reg) begin
      m0_phase_reg <= m0_bit_end ? 4'h0 : m0_phase_reg + 4'h1;
      if (m0_bit_end) begin
        // Input is sampled at the end of the clock-high half, after synchroniser delay.
        if (m0_rx_reg) begin
          m0_shift_reg <= {rxd_s, m0_shift_reg[7:1]};
        end else begin
          m0_shift_reg <= {1'b1, m0_shift_reg[7:1]};
        end
        m0_bit_reg <= m0_bit_reg + 3'h1;
        if (m0_end) begin
          m0_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Control, flags and rate settings; a hardware set wins over a same-cycle clear.
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg <= `FMSP_MODE0;
      mp_reg <= 1'b0;
      ren_reg <= 1'b0;
      tb8_reg <= 1'b0;
      rb8_reg <= 1'b0;
      ti_reg <= 1'b0;
      ri_reg <= 1'b0;
      rx_buf_reg <= `FMSP_RST_BYTE;
      rate_doubling_bit_reg <= 1'b0;
      timer_mode_register_reg <= `FMSP_RST_BYTE;
      t1_reload_reg <= `FMSP_RST_BYTE;
      t2sel_reg <= 1'b0;
      cap_reg <= `FMSP_RST_CAP;
    end else begin
      if (wr_ctrl) begin
        mode_reg <= {i_wdata[`FMSP_BIT_MODE_HI], i_wdata[`FMSP_BIT_MODE_LO]};
        mp_reg <= i_wdata[`FMSP_BIT_MP];
        ren_reg <= i_wdata[`FMSP_BIT_REN];
        tb8_reg <= i_wdata[`FMSP_BIT_TB8];
      end
      if (ti_set_async || ti_set_m0) begin
        ti_reg <= 1'b1;
      end else if (wr_ctrl) begin
        ti_reg <= i_wdata[`FMSP_BIT_TI];
      end
      if (rx_load_async || rx_load_m0) begin
        ri_reg <= 1'b1;
        // In Mode 0 the eighth bit shifts in on this same edge, so it comes from the pin.
        rx_buf_reg <= rx_load_m0 ? {rxd_s, m0_shift_reg[7:1]} : rx_data;
      end else if (wr_ctrl) begin
        ri_reg <= i_wdata[`FMSP_BIT_RI];
      end
      if (rx_load_async) begin
        rb8_reg <= rx_flag_bit;
      end else if (wr_ctrl) begin
        rb8_reg <= i_wdata[`FMSP_BIT_RB8];
      end
      if (i_wr && (i_addr == `FMSP_ADDR_PWR)) begin
        rate_doubling_bit_reg <= i_wdata[`FMSP_BIT_RATE_DOUBLING_BIT];
      end
      if (i_wr && (i_addr == `FMSP_ADDR_TIMER_MODE_REGISTER)) begin
        timer_mode_register_reg <= i_wdata;
      end
      if (i_wr && (i_addr == `FMSP_ADDR_T1RL)) begin
        t1_reload_reg <= i_wdata;
      end
      if (i_wr && (i_addr == `FMSP_ADDR_TIMER2_CONTROL)) begin
        t2sel_reg <= i_wdata[`FMSP_BIT_TIMER2_RATE_CLOCK_SELECT];
      end
      if (i_wr && (i_addr == `FMSP_ADDR_CAPL)) begin
        cap_reg[7:0] <= i_wdata;
      end
      if (i_wr && (i_addr == `FMSP_ADDR_CAPH)) begin
        cap_reg[15:8] <= i_wdata;
      end
    end
  end

  // Read decode; unmapped addresses read zero.
  always @* begin
    rd_next = 8'h00;
    case (i_addr)
      `FMSP_ADDR_CTRL: begin
        rd_next = {mode_reg, mp_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
      end
      `FMSP_ADDR_BUF: begin
        rd_next = rx_buf_reg;
      end
      `FMSP_ADDR_PWR: begin
        rd_next = {rate_doubling_bit_reg, 7'h00};
      end
      `FMSP_ADDR_TIMER_MODE_REGISTER: begin
        rd_next = timer_mode_register_reg;
      end
      `FMSP_ADDR_T1RL: begin
        rd_next = t1_reload_reg;
      end
      `FMSP_ADDR_TIMER2_CONTROL: begin
        rd_next = {2'h0, t2sel_reg, 5'h00};
      end
      `FMSP_ADDR_CAPL: begin
        rd_next = cap_reg[7:0];
      end
      `FMSP_ADDR_CAPH: begin
        rd_next = cap_reg[15:8];
      end
      default: begin
        rd_next = 8'h00;
      end
    endcase
  end

  // Registered outputs: read data and pins.
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
      o_txd <= 1'b1;
      o_rxd <= 1'b1;
      o_rxd_oe_n <= 1'b1;
    end else begin
      o_rdata <= i_rd ? rd_next : 8'h00;
      if (async) begin
        o_txd <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
        o_rxd <= 1'b1;
        o_rxd_oe_n <= 1'b1;
      end else begin
        // The shift clock is low in the first half of each bit, when the data changes.
        o_txd <= m0_busy_reg ? (m0_phase_reg >= `FMSP_M0_RISE) : 1'b1;
        o_rxd <= m0_shift_reg[0];
        o_rxd_oe_n <= !(m0_busy_reg && !m0_rx_reg);
      end
    end
  end
endmodule // fmsp_top

// *** fmsp_top_monitor.sv ***
// Checker for the serial port register port and pins.
// Assumes binding to fmsp_top, one clock domain, reset low.
module fmsp_top_monitor (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_rxd,
  input wire o_rxd,
  input wire o_rxd_oe_n,
  input wire o_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] low_run;
  // Counts how long the data pin has been driven in one stretch.
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) low_run <= 8'h00;
    else low_run <= o_rxd_oe_n ? 8'h00 : low_run + 8'h01;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_ctrl_readback: assert property (
    i_wr && i_addr == 8'h98 ##2 i_rd && i_addr == 8'h98
    |=> o_rdata[7:3] == $past(i_wdata[7:3], 3))
    else $error("control bits not held");
  chk_buf_start: assert property (i_wr && i_addr == 8'h99 |-> ##[1:3] !o_txd)
    else $error("buffer write started nothing");
  chk_shift_low: assert property (
    $fell(o_txd) && !o_rxd_oe_n |=> !o_txd [*5] ##1 o_txd)
    else $error("shift clock low phase wrong");
  chk_shift_high: assert property ($rose(o_txd) && !o_rxd_oe_n |=> o_txd [*5])
    else $error("shift clock high phase wrong");
  chk_shift_hold: assert property (
    !o_rxd_oe_n && $past(!o_rxd_oe_n) && $changed(o_rxd) |-> !o_txd)
    else $error("data changed while shift clock high");
  chk_drive_len: assert property (low_run <= 8'h64)
    else $error("data pin driven too long");
  chk_reset_idle: assert property ($rose(i_reset_n) |-> o_txd && o_rxd_oe_n && o_rdata == 8'h00)
    else $error("outputs not idle after reset");
endmodule // fmsp_top_monitor

// *** test_four_mode_serial_port.sv ***
// Self-checking bench for the four-mode serial port.
// Assumes fmsp_top, fmsp_peer and the monitor are compiled first.
module test_four_mode_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  reg i_mclk, i_reset_n, i_wr, i_rd;
  reg [7:0] i_addr, i_wdata, rv;
  wire [7:0] o_rdata;
  wire o_rxd, o_rxd_oe_n, o_txd, peer_rxd;
  wire pin = o_rxd_oe_n ? peer_rxd : o_rxd;
  int fails, comparisons, cycles;
  fmsp_top dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(pin),
    .o_rxd(o_rxd), .o_rxd_oe_n(o_rxd_oe_n), .o_txd(o_txd));
  fmsp_peer peer_u (.i_mclk(i_mclk), .i_txd(o_txd), .i_pin(pin),
    .i_oe_n(o_rxd_oe_n), .o_rxd(peer_rxd));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic close_out;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input [7:0] seen, input [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input [7:0] a, output [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_mclk);
  endtask
  // Sends one byte while receiving another; bit times are bc clocks.
  task automatic tx_case(input [7:0] c, input [7:0] p, input [7:0] t2, input int bc,
    input int n);
    reg [10:0] want, rxf;
    reg [7:0] d;
    int t;
    d = c ^ 8'h6B;
    want = {1'b1, (n == 10) ? 1'b1 : c[3], d, 1'b0};
    rxf = {1'b1, (n == 10) ? 1'b1 : ~c[3], ~d, 1'b0};
    wr(8'h87, p);
    wr(8'hC8, t2);
    wr(8'h98, c);
    rd(8'h98, rv);
    check(rv, c);
    fork
      peer_u.send(rxf, n, bc);
      begin
        wr(8'h99, d);
        t = 0;
        for (int k = 0; k < n; k++) begin
          while (t < k * bc + bc / 2) begin
            @(posedge i_mclk);
            t++;
          end
          check({7'h00, o_txd}, {7'h00, want[k]});
          if (k >= n - 2) begin
            rd(8'h98, rv);
            t += 2;
            check({7'h00, rv[1]}, {7'h00, k == n - 1});
          end
        end
      end
    join
    repeat (4) @(posedge i_mclk);
    rd(8'h99, rv);
    check(rv, ~d);
    rd(8'h98, rv);
    check({5'h00, rv[2:0]}, {5'h00, rxf[9], 2'b11});
  endtask
  task automatic rx_case(input [7:0] c, input [10:0] f, input int n, input ri,
    input [7:0] b);
    wr(8'h98, c);
    peer_u.send(f, n, 32);
    repeat (4) @(posedge i_mclk);
    rd(8'h98, rv);
    check({7'h00, rv[0]}, {7'h00, ri});
    rd(8'h99, rv);
    check(rv, b);
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    rd(8'h98, rv);
    check(rv, 8'h00);
    rd(8'h00, rv);
    check(rv, 8'h00);
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hFF);
    wr(8'hCA, 8'hFF);
    wr(8'hCB, 8'hFF);
    tx_case(8'h50, 8'h00, 8'h20, 32, 10);
    tx_case(8'h98, 8'h80, 8'h00, 32, 11);
    tx_case(8'h90, 8'h00, 8'h00, 64, 11);
    tx_case(8'hD8, 8'h80, 8'h00, 192, 11);
    wr(8'hC8, 8'h20);
    wr(8'h87, 8'h80);
    rx_case(8'hB0, 11'h422, 11, 1'b0, 8'h4C);
    rx_case(8'hB0, 11'h644, 11, 1'b1, 8'h22);
    rx_case(8'hB1, 11'h666, 11, 1'b1, 8'h22);
    rx_case(8'h80, 11'h688, 11, 1'b0, 8'h22);
    rx_case(8'h70, 11'h0AA, 10, 1'b0, 8'h22);
    rx_case(8'h70, 11'h2AA, 10, 1'b1, 8'h55);
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h96);
    repeat (110) @(posedge i_mclk);
    check(peer_u.m0_in, 8'h96);
    rd(8'h98, rv);
    check({6'h00, rv[1:0]}, 8'h02);
    fork
      peer_u.m0_send(8'h3C);
      wr(8'h98, 8'h10);
    join
    repeat (20) @(posedge i_mclk);
    rd(8'h99, rv);
    check(rv, 8'h3C);
    rd(8'h98, rv);
    check({7'h00, rv[0]}, 8'h01);
    close_out();
  end
endmodule // test_four_mode_serial_port
bind fmsp_top fmsp_top_monitor mon_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rxd(i_rxd), .o_rxd(o_rxd), .o_rxd_oe_n(o_rxd_oe_n), .o_txd(o_txd));
